// [bench/tb_top.sv]
// self-checking bench for the line code violation counter readback block over ahb-lite
`timescale 1ns/1ns
`include "lcvrb_params.svh"
module tb_top;
    import lcvrb_pkg::*;
    // ==========================================
    // signals
    logic         hclk;
    logic         hresetn;
    logic         hsel;
    lcvrb_word_t  haddr;
    lcvrb_trans_t htrans;
    logic         hwrite;
    lcvrb_size_t  hsize;
    lcvrb_word_t  hwdata;
    lcvrb_word_t  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic [13:0]  line_code_violation;
    int           num_errors;
    int           checked;
    lcvrb_word_t  rd;
    // ==========================================
    // design, hready looped back from the only slave
    lcvrb_top #(.CH(14)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_code_violation(line_code_violation));
    // clock, 10 ns period
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ==========================================
    // one single word transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer
    task automatic chk(input lcvrb_word_t got, input lcvrb_word_t exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // read a register and compare its word
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
        chk({31'h0, hresp}, 32'h00000000);
    endtask : rdchk
    // n rising edges on one channel, each wide enough for the synchroniser
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            @(posedge hclk);
            line_code_violation[ch] <= 1'b1;
            repeat (2) @(posedge hclk);
            line_code_violation[ch] <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
    endtask : pulse
    // clear bits must stay high for the full hold time
    task automatic clear(input logic [7:0] bits);
        xfer(1'b1, `LCVRB_IDX_CTRL, bits);
        repeat (`LCVRB_CLR_HOLD_CYC) @(posedge hclk);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h00);
    endtask : clear
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // ==========================================
    // watchdog: the tests need a few thousand cycles
    initial
    begin
        repeat (40000) @(posedge hclk);
        num_errors++;
        print_verdict();
    end
    // ==========================================
    // main sequence
    initial
    begin
        num_errors = 0;
        checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        line_code_violation = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, spare storage, unmapped and ignored writes
        rdchk(`LCVRB_IDX_CTRL, 8'h00);
        rdchk(`LCVRB_IDX_SPARE, 8'h00);
        rdchk(`LCVRB_IDX_CHAN, 8'h00);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        xfer(1'b1, `LCVRB_IDX_SPARE, 8'ha5);
        rdchk(`LCVRB_IDX_SPARE, 8'ha5);
        xfer(1'b1, 8'h10, 8'h5a);
        rdchk(8'h10, 8'h00);
        xfer(1'b1, `LCVRB_IDX_BYTE, 8'hff);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        $display("test reset done");
        // 300 events on channel 2 give 012c, 3 on channel 5
        pulse(2, 300);
        pulse(5, 3);
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h02);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h02);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h42);
        rdchk(`LCVRB_IDX_BYTE, 8'h2c);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h04);
        rdchk(`LCVRB_IDX_BYTE, 8'h01);
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h45);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h00);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h08);
        rdchk(`LCVRB_IDX_BYTE, 8'h03);
        pulse(5, 2);
        rdchk(`LCVRB_IDX_BYTE, 8'h03);
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h4e);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        $display("test latch done");
        // per-channel clear leaves the other channel counting
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h42);
        clear(8'h01);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h08);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        xfer(1'b1, `LCVRB_IDX_CHAN, 8'h45);
        rdchk(`LCVRB_IDX_BYTE, 8'h05);
        clear(8'h10);
        xfer(1'b1, `LCVRB_IDX_CTRL, 8'h08);
        rdchk(`LCVRB_IDX_BYTE, 8'h00);
        $display("test clear done");
        print_verdict();
    end
endmodule : tb_top

// [hw/lcvrb_top.sv]
// per-channel line code violation counters with latched byte readback over ahb-lite
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "lcvrb_params.svh"

// Notes on behaviour
// RULE1 - latch_all_counts written one copies all 14 counters into holding registers
// RULE2 - latch_selected_count written one copies only the selected channel's counter
// RULE3 - counter_channel_select picks channel for latch, clear and byte readback
// RULE4 - count_byte_select zero gives low byte, one gives high; low after reset
// RULE5 - per-channel clear bit zeroes selected counter; software holds it one microsecond
// RULE6 - count byte register returns chosen byte of selected channel's held count
// RULE7 - after reset low byte chosen and no channel selected until programmed
// RULE8 - register after control is plain spare storage, resets zero, no effect
// RULE9 - each counter is sixteen bits and saturates at maximum until cleared
// RULE10 - clear_all_counts zeroes every counter; software holds it one microsecond
// RULE11 - count byte readback works only while count_readback_enable is one
// RULE12 - holding registers keep latched values until next latch or reset
module lcvrb_top
#(
    parameter int CH = 14                           // number of line channels
)
(
    input  wire logic                  hclk,        // bus clock, 100 mhz
    input  wire logic                  hresetn,     // async reset, active low
    input  wire logic                  hsel,        // slave select
    input  wire lcvrb_pkg::lcvrb_word_t haddr,      // byte address
    input  wire lcvrb_pkg::lcvrb_trans_t htrans,    // transfer type
    input  wire logic                  hwrite,      // write when high
    input  wire lcvrb_pkg::lcvrb_size_t hsize,      // word transfers only
    input  wire lcvrb_pkg::lcvrb_word_t hwdata,     // write data
    input  wire logic                  hready,      // bus ready
    output lcvrb_pkg::lcvrb_word_t     hrdata,      // read data, registered
    output logic                       hreadyout,   // low in read wait cycle
    output logic                       hresp,       // always okay
    input  wire logic [CH-1:0]         line_code_violation // async violation pulses
);
    import lcvrb_pkg::*;

    // ==========================================
    // state
    typedef struct packed
    {
        logic [CH-1:0][15:0] cnt;     // live counters
        logic [CH-1:0][15:0] hold;    // latched copies
        logic [CH-1:0]       sync1;   // first sync stage
        logic [CH-1:0]       sync2;   // second sync stage
        logic [CH-1:0]       sync3;   // edge history
        logic [7:0]          chan;    // channel / enable register
        logic                selv;    // channel has been programmed
        logic [7:0]          ctrl;    // control register
        logic [7:0]          spare;   // unused storage
        logic                ap_v;    // data phase pending
        logic                ap_w;    // pending is a write
        lcvrb_idx_t          ap_idx;  // pending register index
        logic                rd_wait; // read wait cycle done
        logic [7:0]          rdata;   // read data
    } lcvrb_state_t;

    lcvrb_state_t st_q;
    lcvrb_state_t st_d;

    // ==========================================
    // helpers
    function automatic logic [7:0] pick_byte(input logic [15:0] v, input lcvrb_byte_t b);
        pick_byte = (b == LCVRB_BYTE_HIGH) ? v[15:8] : v[7:0];
    endfunction : pick_byte

    function automatic logic chan_ok(input logic [3:0] c, input logic v);
        chan_ok = v && (32'(c) < CH);
    endfunction : chan_ok

    function automatic logic is_chan(input logic [3:0] c, input int i);
        is_chan = (32'(c) == i);
    endfunction : is_chan

    logic [3:0]  ch;
    logic        ch_ok;
    logic        rden;
    lcvrb_byte_t bsel;
    logic        clr_all;
    logic        clr_sel;
    logic        wr;
    logic        wr_ctl;
    logic        lat_all;
    logic        lat_sel;
    logic [CH-1:0] hit;
    logic [15:0] cnt_of_sel;
    logic [15:0] hold_of_sel;
    logic [7:0]  byte_rd;

    // field views of stored registers
    assign ch      = st_q.chan[`LCVRB_CHAN_SEL_HI:`LCVRB_CHAN_SEL_LO];
    assign ch_ok   = chan_ok(ch, st_q.selv);
    assign rden    = st_q.chan[`LCVRB_CHAN_RDEN_BIT];
    assign bsel    = lcvrb_byte_t'(st_q.ctrl[`LCVRB_CTRL_COUNT_BYTE_SELECT]);
    assign clr_all = st_q.ctrl[`LCVRB_CTRL_CLRALL];
    assign clr_sel = st_q.ctrl[`LCVRB_CTRL_CLRSEL] && ch_ok;
    assign cnt_of_sel  = ch_ok ? st_q.cnt[ch] : 16'h0000;
    assign hold_of_sel = ch_ok ? st_q.hold[ch] : 16'h0000;

    // write strobes act in the data phase, latch pulses come from the write itself
    assign wr      = st_q.ap_v && st_q.ap_w;
    assign wr_ctl  = wr && (st_q.ap_idx == `LCVRB_IDX_CTRL);
    assign lat_all = wr_ctl && hwdata[`LCVRB_CTRL_LATALL];
    assign lat_sel = wr_ctl && hwdata[`LCVRB_CTRL_LATSEL] && ch_ok;

    // rising edges after the second sync stage only
    assign hit = st_q.sync2 & ~st_q.sync3;

    // RULE6 byte readback mux
    // RULE11 gated by readback enable; RULE7 zero until a channel is chosen
    assign byte_rd = (rden && ch_ok) ? pick_byte(hold_of_sel, bsel) : 8'h00;

    // ==========================================
    // bus outputs; only reads insert one wait cycle
    assign hreadyout = !(st_q.ap_v && !st_q.ap_w && !st_q.rd_wait);
    assign hresp     = 1'b0;
    assign hrdata    = {24'h000000, st_q.rdata};

    // ==========================================
    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.sync1   = line_code_violation;
        st_d.sync2   = st_q.sync1;
        st_d.sync3   = st_q.sync2;
        st_d.rd_wait = 1'b0;

        // read value taken after any write ahead of it has landed
        if (st_q.ap_v && !st_q.ap_w && !st_q.rd_wait)
        begin
            st_d.rd_wait = 1'b1;
            unique case (st_q.ap_idx)
                `LCVRB_IDX_CHAN:  st_d.rdata = st_q.chan;
                `LCVRB_IDX_CTRL:  st_d.rdata = st_q.ctrl;
                `LCVRB_IDX_SPARE: st_d.rdata = st_q.spare;
                `LCVRB_IDX_BYTE:  st_d.rdata = byte_rd;
                default:          st_d.rdata = 8'h00;
            endcase
        end

        // address phase capture; unmapped or high addresses decode to no register
        if (hready && hsel && htrans[1])
        begin
            st_d.ap_v   = 1'b1;
            st_d.ap_w   = hwrite;
            st_d.ap_idx = (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'h00;
        end
        else if (hreadyout)
        begin
            st_d.ap_v = 1'b0;
        end

        // register writes; count byte register ignores writes
        if (wr)
        begin
            unique case (st_q.ap_idx)
                `LCVRB_IDX_CHAN:
                begin
                    st_d.chan = hwdata[7:0];
                    st_d.selv = 1'b1;
                end
                `LCVRB_IDX_CTRL:  st_d.ctrl = hwdata[7:0];
                // RULE8 spare storage only
                `LCVRB_IDX_SPARE: st_d.spare = hwdata[7:0];
                default:          st_d.spare = st_q.spare;
            endcase
        end

        for (int i = 0; i < CH; i++)
        begin
            // RULE1 all holding registers copy at once
            // RULE2 only the selected one; RULE12 otherwise kept
            if (lat_all || (lat_sel && is_chan(ch, i)))
                st_d.hold[i] = st_q.cnt[i];
            // RULE10 clear all, RULE5 and RULE3 clear selected, while bit is one
            if (clr_all || (clr_sel && is_chan(ch, i)))
                st_d.cnt[i] = 16'h0000;
            // RULE9 saturating count
            else if (hit[i] && (st_q.cnt[i] != `LCVRB_CNT_MAX))
                st_d.cnt[i] = st_q.cnt[i] + 16'h0001;
        end
    end

    // ==========================================
    // state register; RULE4 and RULE7 all fields reset to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ==========================================
    // checks
    sequence s_rd_byte;
        hready && hsel && htrans == 2'b10 && !hwrite && haddr == {22'h000000, `LCVRB_IDX_BYTE, 2'b00};
    endsequence

    sequence s_rd_done;
        !hreadyout ##1 hreadyout;
    endsequence

    a_latch_all_copy: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        lat_all |=> st_q.hold == $past(st_q.cnt))
        else $error("latch all did not copy counters");

    a_latch_sel_copy: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        (lat_sel && !lat_all) |=> hold_of_sel == $past(cnt_of_sel))
        else $error("latch selected did not copy");

    a_read_byte_value: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        s_rd_byte ##1 s_rd_done |-> hrdata[7:0] == $past(byte_rd))
        else $error("count byte read wrong");

    a_readback_off_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        (s_rd_byte ##1 !rden && !hreadyout) |=> hrdata == 32'h00000000)
        else $error("readback returned data while disabled");

    a_byte_sel_high: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        (rden && ch_ok && bsel == LCVRB_BYTE_HIGH) |-> byte_rd == hold_of_sel[15:8])
        else $error("high byte not selected");

    a_no_chan_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        !st_q.selv |-> byte_rd == 8'h00 && hold_of_sel == 16'h0000)
        else $error("channel selected before programming");

    a_clear_sel_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
        (clr_sel ##1 $stable(ch)) |-> cnt_of_sel == 16'h0000)
        else $error("selected counter not cleared");

    a_clear_all_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        clr_all |=> st_q.cnt == '0)
        else $error("counters not all cleared");

    a_saturate_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        (cnt_of_sel == 16'hffff && !clr_all && !clr_sel ##1 $stable(ch)) |-> cnt_of_sel == 16'hffff)
        else $error("counter left saturation");

    a_hold_stable: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
        $changed(st_q.hold) |-> $past(lat_all || lat_sel))
        else $error("holding register changed without latch");

    a_spare_only_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        $changed(st_q.spare) |-> $past(wr && st_q.ap_idx == `LCVRB_IDX_SPARE))
        else $error("spare changed without write");

    // ==========================================
    // bus handshake checks
    sequence s_rd_pending;
        st_q.ap_v && !st_q.ap_w && !st_q.rd_wait;
    endsequence

    // one wait state so read data always comes from a flop
    a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        s_rd_pending |-> s_rd_done)
        else $error("read wait state wrong");

    // writes never stall, so latch pulses stay single cycle
    a_write_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        (st_q.ap_v && st_q.ap_w) |-> hreadyout)
        else $error("write data phase stalled");

    // ==========================================
    // readback and counter checks
    logic [CH-1:0] hold_moved;

    // which holding registers move at the next edge
    always_comb
    begin
        for (int i = 0; i < CH; i++)
            hold_moved[i] = (st_d.hold[i] != st_q.hold[i]);
    end

    a_latch_sel_only: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        (lat_sel && !lat_all) |-> (hold_moved & ~(CH'(1) << ch)) == '0)
        else $error("latch selected touched another channel");

    a_readback_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        !rden |-> byte_rd == 8'h00)
        else $error("count byte nonzero while readback disabled");

    a_byte_sel_low: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        (rden && ch_ok && bsel == LCVRB_BYTE_LOW) |-> byte_rd == hold_of_sel[7:0])
        else $error("low byte not selected");

    a_chan_write_sel: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        (wr && st_q.ap_idx == `LCVRB_IDX_CHAN) |=> st_q.selv)
        else $error("channel write did not select");

    // without a clear the selected counter steps by one at most per edge
    sequence s_sel_steady;
        ch_ok && !clr_all && !clr_sel ##1 $stable(ch);
    endsequence

    a_count_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        s_sel_steady |-> (cnt_of_sel - $past(cnt_of_sel)) <= 16'h0001)
        else $error("counter moved by more than one");

    a_sync_before_hit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        (hit & ~$past(line_code_violation, 2)) == '0)
        else $error("edge counted before two sync stages");

    a_clear_keeps_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
        (clr_all && !lat_all && !lat_sel) |=> st_q.hold == $past(st_q.hold))
        else $error("clear all disturbed holding registers");

    a_spare_no_effect: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        (wr && st_q.ap_idx == `LCVRB_IDX_SPARE) |=>
        st_q.hold == $past(st_q.hold) && st_q.ctrl == $past(st_q.ctrl))
        else $error("spare write changed behaviour");

endmodule : lcvrb_top

// [include/lcvrb_params.svh]
// offsets, field positions, reset values and timing for the line code violation counter readback block
`ifndef LCVRB_PARAMS_SVH
`define LCVRB_PARAMS_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define LCVRB_IDX_CHAN      8'he5
`define LCVRB_IDX_CTRL      8'he6
`define LCVRB_IDX_SPARE     8'he7
`define LCVRB_IDX_BYTE      8'he8

// ==========================================
// channel/enable register fields
`define LCVRB_CHAN_SEL_HI   3
`define LCVRB_CHAN_SEL_LO   0
`define LCVRB_CHAN_RDEN_BIT 6

// ==========================================
// control register fields
`define LCVRB_CTRL_CLRALL   4
`define LCVRB_CTRL_LATALL   3
`define LCVRB_CTRL_COUNT_BYTE_SELECT  2
`define LCVRB_CTRL_LATSEL   1
`define LCVRB_CTRL_CLRSEL   0

// ==========================================
// reset values
`define LCVRB_RST_CHAN      8'h00
`define LCVRB_RST_CTRL      8'h00
`define LCVRB_RST_SPARE     8'h00
`define LCVRB_CNT_MAX       16'hffff

// ==========================================
// timing: clear bits held by software at least this long
`define LCVRB_CLK_NS        10
`define LCVRB_CLR_HOLD_NS   1000
`define LCVRB_CLR_HOLD_CYC  ((`LCVRB_CLR_HOLD_NS + `LCVRB_CLK_NS - 1) / `LCVRB_CLK_NS)

`endif

// [include/lcvrb_pkg.sv]
// types shared by the line code violation counter readback block
package lcvrb_pkg;

    // ==========================================
    // bus and register types
    typedef logic [31:0] lcvrb_word_t;
    typedef logic [7:0]  lcvrb_idx_t;
    typedef logic [1:0]  lcvrb_trans_t;
    typedef logic [2:0]  lcvrb_size_t;
    typedef logic [15:0] lcvrb_count_t;

    // ==========================================
    // byte choice for readback
    typedef enum logic
    {
        LCVRB_BYTE_LOW  = 1'b0,
        LCVRB_BYTE_HIGH = 1'b1
    } lcvrb_byte_t;

endpackage : lcvrb_pkg
